// ==== test/register_transfer_instructions_tb.sv ====
// Self-checking bench for the register-transfer unit
`timescale 1ns/1ps
module register_transfer_instructions_tb;
  typedef struct packed {logic [7:0] ab; logic [4:0] op; logic [1:0] sel;
    logic [3:0] j; logic [11:0] ra; logic [15:0] ex;} rti_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  t4;
  int          err_total, compares;
  rti_row_t    rows [22];

  rti_core i_rti_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer4_q_o(t4));

  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 20) begin
      chk("wait bound", 32'h0, 32'h1);
      summarize();
    end
  endtask

  // One APB transfer, entered just after an edge; bb keeps psel up for a follower
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic bb = 1'b0);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(negedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(negedge pclk);
    end
    tmo(n);
    rd = prdata;
    er = pslverr;
    @(posedge pclk);
    if (!bb) begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  // Poll until the unit is idle again
  task automatic idle();
    int n;
    n = 0;
    do begin
      xfer(1'b0, 12'h008, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
    tmo(n);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    err_total = 0;
    compares = 0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Source registers, RAM word at X 3 Y 5, ROM word at 14'h0969
    xfer(1'b1, 12'h00C, 32'h11);
    xfer(1'b1, 12'h010, 32'hC35A);
    xfer(1'b1, 12'h014, 32'h9E7D6C4B);
    xfer(1'b1, 12'h018, 32'h000506B7);
    xfer(1'b1, 12'h01C, 32'h00654321);
    xfer(1'b1, 12'h020, 32'h00000A98);
    xfer(1'b1, 12'h028, 32'h00070003);
    xfer(1'b1, 12'h024, 32'hD);
    xfer(1'b1, 12'h02C, 32'h096902A7);
    // Preset AB, command, register read, expected value
    rows[0]  = '{8'h00, 5'h03, 2'h0, 4'h0, 12'h00C, 16'h005A};
    rows[1]  = '{8'h2E, 5'h01, 2'h0, 4'h0, 12'h00C, 16'h002E};
    rows[2]  = '{8'h94, 5'h02, 2'h0, 4'h0, 12'h010, 16'h942E};
    rows[3]  = '{8'hC3, 5'h04, 2'h0, 4'h0, 12'h004, 16'h00CC};
    rows[4]  = '{8'hFF, 5'h05, 2'h0, 4'h0, 12'h004, 16'h004B};
    rows[5]  = '{8'hFF, 5'h05, 2'h1, 4'h0, 12'h004, 16'h006C};
    rows[6]  = '{8'hFF, 5'h05, 2'h2, 4'h0, 12'h004, 16'h007D};
    rows[7]  = '{8'hFF, 5'h05, 2'h3, 4'h0, 12'h004, 16'h002E};
    rows[8]  = '{8'h00, 5'h06, 2'h0, 4'h0, 12'h004, 16'h00B7};
    rows[9]  = '{8'h09, 5'h07, 2'h0, 4'h0, 12'h004, 16'h00A7};
    rows[10] = '{8'h00, 5'h08, 2'h0, 4'h0, 12'h004, 16'h009E};
    rows[11] = '{8'h5F, 5'h09, 2'h0, 4'h0, 12'h004, 16'h0056};
    rows[12] = '{8'h70, 5'h0A, 2'h0, 4'h0, 12'h004, 16'h0071};
    rows[13] = '{8'h70, 5'h0A, 2'h1, 4'h0, 12'h004, 16'h0072};
    rows[14] = '{8'h80, 5'h0B, 2'h0, 4'h0, 12'h004, 16'h0083};
    rows[15] = '{8'h80, 5'h0B, 2'h1, 4'h0, 12'h004, 16'h0084};
    rows[16] = '{8'h80, 5'h0B, 2'h2, 4'h0, 12'h004, 16'h0085};
    rows[17] = '{8'h90, 5'h0C, 2'h0, 4'h0, 12'h004, 16'h0096};
    rows[18] = '{8'hC0, 5'h0D, 2'h0, 4'hF, 12'h004, 16'h00CD};
    rows[19] = '{8'hA0, 5'h0E, 2'h0, 4'h0, 12'h004, 16'h00A8};
    rows[20] = '{8'hB0, 5'h0F, 2'h0, 4'h0, 12'h004, 16'h00B9};
    rows[21] = '{8'hB0, 5'h0F, 2'h1, 4'h0, 12'h004, 16'h00BA};
    foreach (rows[k]) begin
      xfer(1'b1, 12'h004, {24'h0, rows[k].ab});
      xfer(1'b1, 12'h000, {1'b1, 7'h12, 4'h0, rows[k].j, 6'h0, rows[k].sel, 3'h0, rows[k].op});
      idle();
      xfer(1'b0, rows[k].ra, 32'h0);
      chk($sformatf("row %0d", k), rd & ((rows[k].ra == 12'h010) ? 32'hFFFF : 32'hFF),
          {16'h0, rows[k].ex});
    end
    $display("table done");
    // X flipped by the memory load, timer pin follows the count
    xfer(1'b0, 12'h028, 32'h0);
    chk("ptr", rd, 32'h0007000C);
    chk("t4 pin", {24'h0, t4}, 32'h2E);
    // A write arriving back to back with a running lookup is dropped
    xfer(1'b1, 12'h004, 32'h09);
    xfer(1'b1, 12'h000, 32'h92000007, 1'b1);
    xfer(1'b1, 12'h004, 32'h55);
    idle();
    xfer(1'b0, 12'h004, 32'h0);
    chk("ab busy", rd & 32'hFF, 32'hA7);
    $display("busy done");
    // Unmapped place and the write-only ROM port
    xfer(1'b0, 12'hFF0, 32'h0);
    chk("err rd", {31'h0, er}, 32'h1);
    chk("err data", rd, 32'h0);
    xfer(1'b1, 12'hFF0, 32'hFFFFFFFF);
    chk("err wr", {31'h0, er}, 32'h1);
    xfer(1'b0, 12'h02C, 32'h0);
    chk("romw", rd, 32'h0);
    $display("errors done");
    // Second reset in mid-run
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("t4 rst", {24'h0, t4}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, 12'h008, 32'h0);
    chk("stat rst", rd, 32'h00000700);
    xfer(1'b0, 12'h004, 32'h0);
    chk("ab rst", rd, 32'h0);
    $display("reset done");
    summarize();
  end
endmodule // register_transfer_instructions_tb

// ==== test/rti_core_asserts.sv ====
// Port-level checks for the register-transfer unit
`timescale 1ns/1ps
`include "rti_defs.vh"
module rti_core_asserts (
  input logic        pclk,      // Clock
  input logic        presetn,   // Reset, active low
  input logic        psel,      // APB select
  input logic        penable,   // APB enable
  input logic        pwrite,    // APB write
  input logic [11:0] paddr,     // APB address
  input logic [31:0] pwdata,    // APB write data
  input logic [31:0] prdata,    // APB read data
  input logic        pready,    // APB ready
  input logic        pslverr,   // APB error
  input logic [7:0]  timer4_q_o // Timer 4 count
);
  // Completed transfers seen at the pins
  wire acc_w  = psel && penable && pready;
  wire wr_w   = acc_w && pwrite;
  wire stat_w = acc_w && !pwrite && (paddr == `RTI_OFF_STAT);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Two steps of every transfer
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence

  wait_state_a: assert property (setup_s |=> access_s)
    else $error("no answer after setup");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_phase_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_unmapped_a: assert property (acc_w && paddr > 12'h02C |-> pslverr)
    else $error("unmapped without error");
  err_mapped_a: assert property (acc_w && paddr <= 12'h02C && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped with error");
  err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read not zero");
  flags_kept_a: assert property (stat_w |-> prdata[3:2] == 2'h0)
    else $error("carry or skip moved");
  sp_restored_a: assert property (stat_w && !prdata[0] |-> prdata[10:8] == 3'h7)
    else $error("stack level not restored");
  // Timer 4 moves only by a direct write or a command one cycle after its take
  t4_cause_a: assert property ($changed(timer4_q_o) |->
    $past(wr_w && paddr == `RTI_OFF_T4, 1) ||
    $past(wr_w && paddr == `RTI_OFF_CMD && pwdata[31], 2))
    else $error("timer 4 changed without cause");
endmodule // rti_core_asserts

bind rti_core rti_core_asserts i_rti_core_asserts (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .timer4_q_o);

// ==== verilog/rti_core.v ====
// Register-transfer instruction unit with APB register access
// Operation
// - pair load writes B high, A low into timer 4 and its low reload
// - high reload load writes B to bits 7..4, A to bits 3..0, one cycle
// - reload copy moves all eight low reload bits into timer 4, one cycle
// - B to A move keeps carry and never skips
// - timer read puts count high nibble in B, low in A, one cycle
// - extension read puts E high nibble in B, low in A
// - lookup loads word bits 7..4 to B, 3..0 to A, pushes and pops stack
// - prescaler read puts high nibble in B, low in A, one cycle
// - page offset read copies DR into A bits 2..0, A bit 3 zero
// - interrupt control read copies first or second register into A
// - wakeup read copies one of three wakeup registers into A
// - LCD read copies first LCD register into A, carry and skip kept
// - memory load puts M(DP) into A and X becomes X xor j
// - clock control read copies clock register into A in one cycle
// - pull-up read copies port 0 or port 1 register into A
`timescale 1ns/1ps
`include "rti_defs.vh"
module rti_core (
  input  wire        pclk,      // APB clock, 50 MHz
  input  wire        presetn,   // Asynchronous reset, active low
  input  wire        psel,      // APB select
  input  wire        penable,   // APB enable
  input  wire        pwrite,    // APB write
  input  wire [11:0] paddr,     // APB byte address
  input  wire [31:0] pwdata,    // APB write data
  output reg  [31:0] prdata,    // APB read data
  output reg         pready,    // APB ready
  output reg         pslverr,   // APB error
  output reg  [7:0]  timer4_q_o // Timer 4 count for the timer logic
);
  // Architectural state
  reg [3:0]  acc_q;          // Accumulator
  reg [3:0]  aux_q;          // Auxiliary register B
  reg        carry_flag_q;   // Carry, never touched here
  reg        skip_q;         // Skip state, never touched here
  reg [7:0]  timer4_low_reload_q;
  reg [7:0]  timer4_high_reload_q;
  reg [7:0]  tmr1_q, tmr2_q, tmr3_q;
  reg [7:0]  prescaler_count_q;
  reg [7:0]  ext_q;
  reg [2:0]  page_offset_register_q;
  reg [2:0]  stack_pointer_q;
  reg [3:0]  interrupt_control_first_q, interrupt_control_second_q;
  reg [3:0]  wakeup_control_first_q, wakeup_control_second_q, wakeup_control_third_q;
  reg [3:0]  lcd_control_first_q;
  reg [3:0]  clock_control_register_q;
  reg [3:0]  pullup_control_port0_q, pullup_control_port1_q;
  reg [3:0]  xreg_q;         // Memory file register X
  reg [4:0]  yreg_q;         // Data pointer low part Y
  reg [6:0]  page_q;         // Lookup page operand
  reg        busy_q;
  reg [1:0]  cyc_q;
  reg [4:0]  op_q;
  reg [1:0]  sel_q;
  reg [3:0]  imm_q;
  reg        done_q;         // Sticky completion flag
  // Memory side signals
  reg                     rom_we_q;
  reg [`RTI_ROM_AW-1:0]   rom_waddr_q;
  reg [9:0]               rom_wdata_q;
  reg                     ram_we_q;
  reg [3:0]               ram_wdata_q;
  wire [9:0]              rom_rdata;
  wire [3:0]              ram_rdata;
  wire [`RTI_RAM_AW-1:0]  dp_addr;
  wire [`RTI_ROM_AW-1:0]  lkup_addr;

  // APB access phase decode
  wire acc_en = psel & penable & pready;
  wire wr_en  = acc_en & pwrite;
  wire go     = wr_en && (paddr == `RTI_OFF_CMD) && pwdata[`RTI_CMD_GO] && !busy_q;

  // Data pointer is X:Y, lookup address is page:DR:A
  assign dp_addr   = {xreg_q, yreg_q};
  assign lkup_addr = {page_q, page_offset_register_q, acc_q};

  rti_rom u_rom (
    .pclk  (pclk),
    .we    (rom_we_q),
    .waddr (rom_waddr_q),
    .wdata (rom_wdata_q),
    .raddr (lkup_addr),
    .rdata (rom_rdata)
  );

  rti_ram u_ram (
    .pclk  (pclk),
    .we    (ram_we_q),
    .waddr (dp_addr),
    .wdata (ram_wdata_q),
    .raddr (dp_addr),
    .rdata (ram_rdata)
  );

  // Timer read mux by selector
  reg [7:0] tmr_sel;
  always @* begin
    case (sel_q)
      2'h0:    tmr_sel = tmr1_q;
      2'h1:    tmr_sel = tmr2_q;
      2'h2:    tmr_sel = tmr3_q;
      default: tmr_sel = timer4_q_o;
    endcase
  end

  // Instruction execution; RAM is pre-read so memory load is single cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q                  <= 4'h0;
      aux_q                  <= 4'h0;
      carry_flag_q           <= 1'b0;
      skip_q                 <= 1'b0;
      timer4_q_o             <= 8'h00;
      timer4_low_reload_q    <= 8'h00;
      timer4_high_reload_q   <= 8'h00;
      xreg_q                 <= 4'h0;
      stack_pointer_q        <= 3'h7;
      busy_q                 <= 1'b0;
      cyc_q                  <= 2'h0;
      op_q                   <= 5'h00;
      sel_q                  <= 2'h0;
      imm_q                  <= 4'h0;
      page_q                 <= 7'h00;
      done_q                 <= 1'b0;
    end else begin
      if (go) begin
        busy_q <= 1'b1;
        cyc_q  <= 2'h1;
        op_q   <= pwdata[`RTI_CMD_OP];
        sel_q  <= pwdata[`RTI_CMD_SEL];
        imm_q  <= pwdata[`RTI_CMD_IMM];
        page_q <= pwdata[30:24];
        done_q <= 1'b0;
      end else if (busy_q) begin
        if (op_q == `RTI_OP_ROM_LKUP) begin
          // Stack level borrowed while ROM is read
          cyc_q <= cyc_q + 2'h1;
          if (cyc_q == 2'h1) begin
            stack_pointer_q <= stack_pointer_q + 3'h1;
          end
          if (cyc_q == `RTI_LKUP_CYC) begin
            aux_q           <= rom_rdata[7:4];
            acc_q           <= rom_rdata[3:0];
            stack_pointer_q <= stack_pointer_q - 3'h1;
            busy_q          <= 1'b0;
            done_q          <= 1'b1;
          end
        end else begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          case (op_q)
            `RTI_OP_T4_PAIR: begin
              timer4_q_o          <= {aux_q, acc_q};
              timer4_low_reload_q <= {aux_q, acc_q};
            end
            `RTI_OP_T4_HIGH: timer4_high_reload_q <= {aux_q, acc_q};
            `RTI_OP_T4_COPY: timer4_q_o <= timer4_low_reload_q;
            `RTI_OP_B_TO_A:  acc_q <= aux_q;
            `RTI_OP_TMR_RD: begin
              aux_q <= tmr_sel[7:4];
              acc_q <= tmr_sel[3:0];
            end
            `RTI_OP_EXT_RD: begin
              aux_q <= ext_q[7:4];
              acc_q <= ext_q[3:0];
            end
            `RTI_OP_PS_RD: begin
              aux_q <= prescaler_count_q[7:4];
              acc_q <= prescaler_count_q[3:0];
            end
            `RTI_OP_DR_RD:  acc_q <= {1'b0, page_offset_register_q};
            `RTI_OP_INT_RD: acc_q <= sel_q[0] ? interrupt_control_second_q
                                              : interrupt_control_first_q;
            `RTI_OP_WK_RD:  acc_q <= (sel_q == 2'h0) ? wakeup_control_first_q :
                                     (sel_q == 2'h1) ? wakeup_control_second_q :
                                     wakeup_control_third_q;
            `RTI_OP_LCD_RD: acc_q <= lcd_control_first_q;
            `RTI_OP_MEM_XOR: begin
              acc_q  <= ram_rdata;
              xreg_q <= xreg_q ^ imm_q;
            end
            `RTI_OP_CLK_RD: acc_q <= clock_control_register_q;
            `RTI_OP_PU_RD:  acc_q <= sel_q[0] ? pullup_control_port1_q
                                              : pullup_control_port0_q;
            default: ;
          endcase
        end
      end else if (wr_en && paddr == `RTI_OFF_AB) begin
        // Software preload of A and B while idle
        acc_q <= pwdata[3:0];
        aux_q <= pwdata[7:4];
      end else if (wr_en && paddr == `RTI_OFF_T4) begin
        timer4_q_o <= pwdata[7:0];
      end else if (wr_en && paddr == `RTI_OFF_T4REL) begin
        timer4_low_reload_q  <= pwdata[7:0];
        timer4_high_reload_q <= pwdata[15:8];
      end else if (wr_en && paddr == `RTI_OFF_PTR) begin
        xreg_q          <= pwdata[3:0];
        stack_pointer_q <= pwdata[18:16];
      end
    end
  end

  // Source registers written only from software
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr1_q <= 8'h00;
      tmr2_q <= 8'h00;
      tmr3_q <= 8'h00;
      prescaler_count_q <= 8'h00;
      ext_q <= 8'h00;
      page_offset_register_q <= 3'h0;
      yreg_q <= 5'h00;
      interrupt_control_first_q  <= 4'h0;
      interrupt_control_second_q <= 4'h0;
      wakeup_control_first_q  <= 4'h0;
      wakeup_control_second_q <= 4'h0;
      wakeup_control_third_q  <= 4'h0;
      lcd_control_first_q      <= 4'h0;
      clock_control_register_q <= 4'h0;
      pullup_control_port0_q   <= 4'h0;
      pullup_control_port1_q   <= 4'h0;
    end else if (wr_en && !busy_q) begin
      case (paddr)
        `RTI_OFF_TIMERS: begin
          tmr1_q <= pwdata[7:0];
          tmr2_q <= pwdata[15:8];
          tmr3_q <= pwdata[23:16];
          prescaler_count_q <= pwdata[31:24];
        end
        `RTI_OFF_EXT: begin
          ext_q <= pwdata[7:0];
          page_offset_register_q <= pwdata[10:8];
          yreg_q <= pwdata[20:16];
        end
        `RTI_OFF_CTRL: begin
          interrupt_control_first_q  <= pwdata[3:0];
          interrupt_control_second_q <= pwdata[7:4];
          wakeup_control_first_q  <= pwdata[11:8];
          wakeup_control_second_q <= pwdata[15:12];
          wakeup_control_third_q  <= pwdata[19:16];
          lcd_control_first_q     <= pwdata[23:20];
        end
        `RTI_OFF_CTRL2: begin
          clock_control_register_q <= pwdata[3:0];
          pullup_control_port0_q   <= pwdata[7:4];
          pullup_control_port1_q   <= pwdata[11:8];
        end
        default: ;
      endcase
    end
  end

  // Memory loaders; RAM write uses current data pointer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_we_q    <= 1'b0;
      rom_waddr_q <= {`RTI_ROM_AW{1'b0}};
      rom_wdata_q <= 10'h000;
      ram_we_q    <= 1'b0;
      ram_wdata_q <= 4'h0;
    end else begin
      rom_we_q <= wr_en && !busy_q && (paddr == `RTI_OFF_ROMW);
      ram_we_q <= wr_en && !busy_q && (paddr == `RTI_OFF_MEMW);
      rom_waddr_q <= pwdata[29:16];
      rom_wdata_q <= pwdata[9:0];
      ram_wdata_q <= pwdata[3:0];
    end
  end

  // APB slave: no wait state, answers come from flops loaded in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel & ~penable) begin
        case (paddr)
          `RTI_OFF_CMD:    prdata <= {busy_q, 26'h0, op_q};
          `RTI_OFF_AB:     prdata <= {24'h0, aux_q, acc_q};
          `RTI_OFF_STAT:   prdata <= {21'h0, stack_pointer_q, 4'h0, skip_q, carry_flag_q,
                                      done_q, busy_q};
          `RTI_OFF_T4:     prdata <= {24'h0, timer4_q_o};
          `RTI_OFF_T4REL:  prdata <= {16'h0, timer4_high_reload_q, timer4_low_reload_q};
          `RTI_OFF_TIMERS: prdata <= {prescaler_count_q, tmr3_q, tmr2_q, tmr1_q};
          `RTI_OFF_EXT:    prdata <= {11'h0, yreg_q, 5'h0, page_offset_register_q, ext_q};
          `RTI_OFF_CTRL:   prdata <= {8'h0, lcd_control_first_q, wakeup_control_third_q,
                                      wakeup_control_second_q, wakeup_control_first_q,
                                      interrupt_control_second_q, interrupt_control_first_q};
          `RTI_OFF_CTRL2:  prdata <= {20'h0, pullup_control_port1_q, pullup_control_port0_q,
                                      clock_control_register_q};
          `RTI_OFF_MEMW:   prdata <= {28'h0, ram_rdata};
          `RTI_OFF_PTR:    prdata <= {13'h0, stack_pointer_q, 12'h0, xreg_q};
          `RTI_OFF_ROMW:   prdata <= 32'h00000000;
          default:         pslverr <= 1'b1; // Unmapped address
        endcase
      end
    end
  end
endmodule // rti_core

// ==== verilog/rti_defs.vh ====
// Constants for the register-transfer instruction unit
`ifndef RTI_DEFS_VH
`define RTI_DEFS_VH
// Register byte addresses
`define RTI_OFF_CMD      12'h000
`define RTI_OFF_AB       12'h004
`define RTI_OFF_STAT     12'h008
`define RTI_OFF_T4       12'h00C
`define RTI_OFF_T4REL    12'h010
`define RTI_OFF_TIMERS   12'h014
`define RTI_OFF_EXT      12'h018
`define RTI_OFF_CTRL     12'h01C
`define RTI_OFF_CTRL2    12'h020
`define RTI_OFF_MEMW     12'h024
`define RTI_OFF_PTR      12'h028
`define RTI_OFF_ROMW     12'h02C
// Command codes, written to CMD bits 4..0
`define RTI_OP_T4_PAIR   5'h01
`define RTI_OP_T4_HIGH   5'h02
`define RTI_OP_T4_COPY   5'h03
`define RTI_OP_B_TO_A    5'h04
`define RTI_OP_TMR_RD    5'h05
`define RTI_OP_EXT_RD    5'h06
`define RTI_OP_ROM_LKUP  5'h07
`define RTI_OP_PS_RD     5'h08
`define RTI_OP_DR_RD     5'h09
`define RTI_OP_INT_RD    5'h0A
`define RTI_OP_WK_RD     5'h0B
`define RTI_OP_LCD_RD    5'h0C
`define RTI_OP_MEM_XOR   5'h0D
`define RTI_OP_CLK_RD    5'h0E
`define RTI_OP_PU_RD     5'h0F
// CMD fields
`define RTI_CMD_OP       4:0
`define RTI_CMD_SEL      9:8
`define RTI_CMD_IMM      19:16
`define RTI_CMD_GO       31
// Lookup takes three cycles
`define RTI_LKUP_CYC     2'h3
`define RTI_ROM_AW       14
`define RTI_RAM_AW       9
`endif

// ==== verilog/rti_ram.v ====
// Nibble data RAM with registered read data
`timescale 1ns/1ps
`include "rti_defs.vh"
module rti_ram (
  input  wire                     pclk,    // Clock
  input  wire                     we,      // Write strobe
  input  wire [`RTI_RAM_AW-1:0]   waddr,   // Write address
  input  wire [3:0]               wdata,   // Write nibble
  input  wire [`RTI_RAM_AW-1:0]   raddr,   // Read address
  output reg  [3:0]               rdata    // Registered read nibble
);
  reg [3:0] mem [0:(1<<`RTI_RAM_AW)-1];
  // Single port write, registered read
  always @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // rti_ram

// ==== verilog/rti_rom.v ====
// Program ROM for table lookup, registered read data
`timescale 1ns/1ps
`include "rti_defs.vh"
module rti_rom (
  input  wire                     pclk,    // Clock
  input  wire                     we,      // Write strobe (loader)
  input  wire [`RTI_ROM_AW-1:0]   waddr,   // Write address
  input  wire [9:0]               wdata,   // Write word
  input  wire [`RTI_ROM_AW-1:0]   raddr,   // Read address
  output reg  [9:0]               rdata    // Registered read word
);
  reg [9:0] mem [0:(1<<`RTI_ROM_AW)-1];
  // Single port write, registered read
  always @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // rti_rom
